// file: inc/adc_ctl_pkg.sv
// register map, field layouts, reset values and carrier types of the converter control block
// assumes a plain strobe-based register port and one 250 MHz system clock
package adc_ctl_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  localparam logic [3:0] OFS_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_RESULT = 4'h1;
  localparam logic [3:0] OFS_CLOCK_CONFIG = 4'h2;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h3;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h4;

  // status/control fields
  localparam int SC_DONE_BIT = 7;
  localparam int SC_IRQ_EN_BIT = 6;
  localparam int SC_CONT_BIT = 5;
  localparam int SC_CHAN_LSB = 0;
  localparam int CHAN_W = 5;
  localparam logic [4:0] CHAN_RESET = 5'h1F;

  // clock configuration fields
  localparam int CC_DIV_LSB = 5;
  localparam int DIV_W = 3;
  localparam int CC_SRC_BIT = 4;
  localparam logic [7:0] CLOCK_CONFIG_RESET = 8'h00;

  // interrupt status/mask fields
  localparam int EV_DONE_BIT = 0;
  localparam int EV_OVERRUN_BIT = 1;
  localparam int EV_W = 2;

  localparam int CONV_CYCLES = 17;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [2:0] div;
    logic src_bus;
  } clk_cfg_t;

endpackage

// file: design/adc_clk_divider.sv
// power-of-two divider that makes the converter clock enable
// assumes both source ticks are one-cycle enables on clk_sys
`timescale 1ns/1ps
module adc_clk_divider (
  input wire logic clk_sys,
  input wire logic rst_sync_n,
  input wire logic bus_tick,
  input wire logic xtal_tick,
  input wire adc_ctl_pkg::clk_cfg_t cfg,
  output logic conv_tick
);

  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic conv_tick_ff;
  logic nxt_conv_tick;
  logic src_tick;

  function automatic logic [3:0] div_mask(input logic [2:0] div);
    unique case (div)
      3'h0: div_mask = 4'h0;
      3'h1: div_mask = 4'h1;
      3'h2: div_mask = 4'h3;
      3'h3: div_mask = 4'h7;
      default: div_mask = 4'hF;
    endcase
  endfunction

  always_comb begin
    src_tick = cfg.src_bus ? bus_tick : xtal_tick;
    nxt_cnt = cnt_ff;
    nxt_conv_tick = 1'b0;
    if (src_tick) begin
      if ((cnt_ff & div_mask(cfg.div)) == div_mask(cfg.div)) begin
        nxt_cnt = 4'h0;
        nxt_conv_tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cnt_ff <= 4'h0;
      conv_tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      conv_tick_ff <= nxt_conv_tick;
    end
  end

  assign conv_tick = conv_tick_ff;

endmodule

// file: design/adc_clock_prescaler_result.sv
// digital control of the converter: result register, clock configuration, done flag, interrupt
// assumes the analog core reports each finished conversion as a one-cycle pulse with its code
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
module adc_clock_prescaler_result (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [adc_ctl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [adc_ctl_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [adc_ctl_pkg::DATA_W-1:0] reg_rdata,
  input wire logic crystal_ref_clock,
  input wire logic bus_tick,
  input wire logic conv_finish,
  input wire logic [adc_ctl_pkg::DATA_W-1:0] conv_code,
  output logic conv_tick,
  output logic conv_request,
  output logic continuous_mode,
  output logic [adc_ctl_pkg::CHAN_W-1:0] channel_select,
  output logic converter_irq,
  output logic irq
);

  logic [1:0] rst_pipe_ff;
  logic rst_sync_n;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_ff <= 2'b00;
    end else begin
      rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe_ff[1];

  // crystal reference arrives from a pin: three stages, edge once stages two and three agree
  logic [2:0] xclk_sync_ff;
  logic xclk_stable_ff;
  logic nxt_xclk_stable;
  logic xtal_tick;

  always_comb begin
    nxt_xclk_stable = xclk_stable_ff;
    if (xclk_sync_ff[1] == xclk_sync_ff[2]) begin
      nxt_xclk_stable = xclk_sync_ff[2];
    end
  end
  assign xtal_tick = nxt_xclk_stable & ~xclk_stable_ff;

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      xclk_sync_ff <= 3'h0;
      xclk_stable_ff <= 1'b0;
    end else begin
      xclk_sync_ff <= {xclk_sync_ff[1:0], crystal_ref_clock};
      xclk_stable_ff <= nxt_xclk_stable;
    end
  end

  // register state
  logic [adc_ctl_pkg::DATA_W-1:0] result_ff;
  logic [adc_ctl_pkg::DATA_W-1:0] nxt_result;
  logic [adc_ctl_pkg::DATA_W-1:0] clk_cfg_ff;
  logic [adc_ctl_pkg::DATA_W-1:0] nxt_clk_cfg;
  logic done_ff;
  logic nxt_done;
  logic irq_en_ff;
  logic nxt_irq_en;
  logic cont_ff;
  logic nxt_cont;
  logic [adc_ctl_pkg::CHAN_W-1:0] chan_ff;
  logic [adc_ctl_pkg::CHAN_W-1:0] nxt_chan;
  logic req_ff;
  logic nxt_req;
  logic [adc_ctl_pkg::EV_W-1:0] ev_stat_ff;
  logic [adc_ctl_pkg::EV_W-1:0] nxt_ev_stat;
  logic [adc_ctl_pkg::EV_W-1:0] ev_mask_ff;
  logic [adc_ctl_pkg::EV_W-1:0] nxt_ev_mask;
  logic [adc_ctl_pkg::DATA_W-1:0] rdata_ff;
  logic [adc_ctl_pkg::DATA_W-1:0] nxt_rdata;

  adc_ctl_pkg::reg_req_t req;
  adc_ctl_pkg::clk_cfg_t cfg;
  logic wr_sc;
  logic wr_cc;
  logic rd_res;
  logic clear_done;
  logic [adc_ctl_pkg::EV_W-1:0] ev_set;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign wr_sc = req.wr && (req.addr == adc_ctl_pkg::OFS_STATUS_CONTROL);
  assign wr_cc = req.wr && (req.addr == adc_ctl_pkg::OFS_CLOCK_CONFIG);
  assign rd_res = req.rd && (req.addr == adc_ctl_pkg::OFS_RESULT);
  assign clear_done = wr_sc | rd_res;

  assign cfg.div = clk_cfg_ff[adc_ctl_pkg::CC_DIV_LSB +: adc_ctl_pkg::DIV_W];
  assign cfg.src_bus = clk_cfg_ff[adc_ctl_pkg::CC_SRC_BIT];

  adc_clk_divider u_div (
    .clk_sys(clk_sys),
    .rst_sync_n(rst_sync_n),
    .bus_tick(bus_tick),
    .xtal_tick(xtal_tick),
    .cfg(cfg),
    .conv_tick(conv_tick)
  );

  // overrun: a finish lands while the previous done is still unread
  always_comb begin
    ev_set = '0;
    ev_set[adc_ctl_pkg::EV_DONE_BIT] = conv_finish;
    ev_set[adc_ctl_pkg::EV_OVERRUN_BIT] = conv_finish & done_ff & ~clear_done;
  end

  always_comb begin
    nxt_result = result_ff;
    nxt_clk_cfg = clk_cfg_ff;
    nxt_done = done_ff;
    nxt_irq_en = irq_en_ff;
    nxt_cont = cont_ff;
    nxt_chan = chan_ff;
    nxt_req = 1'b0;
    nxt_ev_stat = ev_stat_ff;
    nxt_ev_mask = ev_mask_ff;
    if (conv_finish) begin
      nxt_result = conv_code;
    end
    if (wr_cc) begin
      // no guard on an active conversion; software keeps settings still meanwhile
      nxt_clk_cfg = '0;
      nxt_clk_cfg[adc_ctl_pkg::CC_DIV_LSB +: adc_ctl_pkg::DIV_W] =
        req.wdata[adc_ctl_pkg::CC_DIV_LSB +: adc_ctl_pkg::DIV_W];
      nxt_clk_cfg[adc_ctl_pkg::CC_SRC_BIT] = req.wdata[adc_ctl_pkg::CC_SRC_BIT];
    end
    if (wr_sc) begin
      nxt_irq_en = req.wdata[adc_ctl_pkg::SC_IRQ_EN_BIT];
      nxt_cont = req.wdata[adc_ctl_pkg::SC_CONT_BIT];
      nxt_chan = req.wdata[adc_ctl_pkg::SC_CHAN_LSB +: adc_ctl_pkg::CHAN_W];
      nxt_req = 1'b1;
    end
    // set wins over clear so a finish in the clearing cycle is kept
    if (clear_done) begin
      nxt_done = 1'b0;
    end
    if (conv_finish) begin
      nxt_done = 1'b1;
    end
    if (req.wr && (req.addr == adc_ctl_pkg::OFS_IRQ_STATUS)) begin
      nxt_ev_stat = ev_stat_ff & ~req.wdata[adc_ctl_pkg::EV_W-1:0];
    end
    nxt_ev_stat = nxt_ev_stat | ev_set;
    if (req.wr && (req.addr == adc_ctl_pkg::OFS_IRQ_MASK)) begin
      nxt_ev_mask = req.wdata[adc_ctl_pkg::EV_W-1:0];
    end
  end

  // read mux; the result offset ignores writes entirely
  always_comb begin
    nxt_rdata = '0;
    if (req.rd) begin
      unique case (req.addr)
        adc_ctl_pkg::OFS_STATUS_CONTROL: begin
          nxt_rdata[adc_ctl_pkg::SC_DONE_BIT] = done_ff;
          nxt_rdata[adc_ctl_pkg::SC_IRQ_EN_BIT] = irq_en_ff;
          nxt_rdata[adc_ctl_pkg::SC_CONT_BIT] = cont_ff;
          nxt_rdata[adc_ctl_pkg::SC_CHAN_LSB +: adc_ctl_pkg::CHAN_W] = chan_ff;
        end
        adc_ctl_pkg::OFS_RESULT: nxt_rdata = result_ff;
        adc_ctl_pkg::OFS_CLOCK_CONFIG: nxt_rdata = clk_cfg_ff;
        adc_ctl_pkg::OFS_IRQ_STATUS: nxt_rdata[adc_ctl_pkg::EV_W-1:0] = ev_stat_ff;
        adc_ctl_pkg::OFS_IRQ_MASK: nxt_rdata[adc_ctl_pkg::EV_W-1:0] = ev_mask_ff;
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      result_ff <= '0;
      clk_cfg_ff <= adc_ctl_pkg::CLOCK_CONFIG_RESET;
      done_ff <= 1'b0;
      irq_en_ff <= 1'b0;
      cont_ff <= 1'b0;
      chan_ff <= adc_ctl_pkg::CHAN_RESET;
      req_ff <= 1'b0;
      ev_stat_ff <= '0;
      ev_mask_ff <= '0;
      rdata_ff <= '0;
    end else begin
      result_ff <= nxt_result;
      clk_cfg_ff <= nxt_clk_cfg;
      done_ff <= nxt_done;
      irq_en_ff <= nxt_irq_en;
      cont_ff <= nxt_cont;
      chan_ff <= nxt_chan;
      req_ff <= nxt_req;
      ev_stat_ff <= nxt_ev_stat;
      ev_mask_ff <= nxt_ev_mask;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  assign conv_request = req_ff;
  assign continuous_mode = cont_ff;
  assign channel_select = chan_ff;
  assign converter_irq = irq_en_ff & done_ff;
  assign irq = |(ev_stat_ff & ev_mask_ff);

endmodule

// file: verification/adc_ctl_monitor.sv
// checker: register, flag, interrupt and divider relations of the converter control
// assumes a bind to the top module, seeing its ports only
`timescale 1ns/1ps
module adc_ctl_monitor (
  input logic clk_sys,
  input logic rst_n,
  input logic [3:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_rdata,
  input logic bus_tick,
  input logic conv_finish,
  input logic [7:0] conv_code,
  input logic conv_tick,
  input logic converter_irq
);
  localparam logic [3:0] a_sc = adc_ctl_pkg::OFS_STATUS_CONTROL;
  localparam logic [3:0] a_res = adc_ctl_pkg::OFS_RESULT;
  localparam logic [3:0] a_cc = adc_ctl_pkg::OFS_CLOCK_CONFIG;
  logic [3:0] cfg_ff, nxt_cfg;
  logic [4:0] cnt_ff, nxt_cnt, ratio;
  logic [1:0] seen_ff, nxt_seen;
  logic cfg_wr, cfg_wr_ff;
  // tick in flight at a change is old; the first new tick still drains the old count
  always_comb begin
    cfg_wr = reg_wr && reg_addr == a_cc;
    nxt_cfg = cfg_wr ? reg_wdata[7:4] : cfg_ff;
    nxt_cnt = conv_tick ? 5'(bus_tick) : cnt_ff + 5'(bus_tick);
    nxt_seen = (cfg_wr || cfg_wr_ff) ? 2'h0 : seen_ff + 2'(conv_tick && seen_ff != 2'h2);
    ratio = cfg_ff[3] ? 5'h10 : 5'h01 << cfg_ff[2:1];
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= 4'h0;
      cnt_ff <= 5'h00;
      seen_ff <= 2'h0;
      cfg_wr_ff <= 1'b0;
    end else begin
      cfg_ff <= nxt_cfg;
      cnt_ff <= nxt_cnt;
      seen_ff <= nxt_seen;
      cfg_wr_ff <= cfg_wr;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_rd(logic [3:0] a);
    reg_rd && reg_addr == a && !conv_finish;
  endsequence
  AST_RESULT_LOAD: assert property (conv_finish ##1 s_rd(a_res) |=> reg_rdata == $past(conv_code, 2))
    else $error("result lost");
  AST_RESULT_RO: assert property (conv_finish ##1 (reg_wr && reg_addr == a_res) ##1 s_rd(a_res)
    |=> reg_rdata == $past(conv_code, 3)) else $error("result written");
  AST_DONE_SET: assert property (conv_finish ##1 s_rd(a_sc) |=> reg_rdata[7])
    else $error("done not set");
  AST_DONE_CLR: assert property ((reg_rd && reg_addr == a_res || reg_wr && reg_addr == a_sc) && !conv_finish
    ##1 s_rd(a_sc) |=> !reg_rdata[7]) else $error("done not cleared");
  AST_IRQ_RISE: assert property ($rose(converter_irq) |-> $past(conv_finish || reg_wr && reg_addr == a_sc))
    else $error("irq without cause");
  AST_IRQ_DROP: assert property (converter_irq && !conv_finish
    && (reg_rd && reg_addr == a_res || reg_wr && reg_addr == a_sc) |=> !converter_irq) else $error("irq held");
  AST_CFG_RB: assert property (cfg_wr ##1 s_rd(a_cc) |=> reg_rdata[7:4] == $past(cfg_ff))
    else $error("config readback");
  AST_DIV_COUNT: assert property (conv_tick && cfg_ff[0] && seen_ff != 2'h0 |-> cnt_ff == ratio)
    else $error("divide ratio");
endmodule

// file: verification/adc_clock_prescaler_result_tb.sv
// bench: directed register sequences against the converter control block
// assumes package, design and checker compiled first
`timescale 1ns/1ps
module adc_clock_prescaler_result_tb;
  localparam logic [3:0] a_sc = adc_ctl_pkg::OFS_STATUS_CONTROL;
  localparam logic [3:0] a_res = adc_ctl_pkg::OFS_RESULT;
  localparam logic [3:0] a_cc = adc_ctl_pkg::OFS_CLOCK_CONFIG;
  logic clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic crystal_ref_clock = 1'b0, bus_tick = 1'b0, conv_finish = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, conv_code = 8'h00, reg_rdata;
  logic conv_tick, converter_irq, irq, conv_request, continuous_mode;
  logic [4:0] channel_select;
  int err_total = 0, n_checks = 0, cyc = 0;
  adc_clock_prescaler_result DUT (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .crystal_ref_clock, .bus_tick, .conv_finish, .conv_code, .conv_tick, .conv_request,
    .continuous_mode, .channel_select, .converter_irq, .irq);
  initial forever #2 clk_sys = ~clk_sys;
  // both sources run always, so a wrong pick shows as a wrong period
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    bus_tick <= cyc % 3 == 0;
    crystal_ref_clock <= cyc[2];
    if (cyc == 20000) begin
      err_total++;
      close_out;
    end
  end
  task automatic chk(input string what, input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, exp);
  endtask
  task automatic fin(input logic [7:0] code);
    conv_finish <= 1'b1;
    conv_code <= code;
    @(posedge clk_sys);
    conv_finish <= 1'b0;
    #1;
  endtask
  // first wait syncs to a tick, second measures one full period
  task automatic gap(input logic [7:0] exp);
    int n;
    repeat (2) begin
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (conv_tick !== 1'b1 && n < 300);
    end
    #1;
    chk("tick_gap", 8'(n), exp);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    rd(a_cc, 8'h00);
    gap(8'd8);
    rd(a_sc, 8'h1F);
    chk("channel_select", 8'(channel_select), 8'h1F);
    wr(a_sc, 8'h25);
    chk("conv_request", 8'(conv_request), 8'h01);
    chk("continuous_mode", 8'(continuous_mode), 8'h01);
    chk("channel_select", 8'(channel_select), 8'h05);
    rd(a_sc, 8'h25);
    chk("conv_request", 8'(conv_request), 8'h00);
    for (int d = 0; d < 8; d++) begin
      wr(a_cc, {3'(d), 1'b1, 4'h0});
      rd(a_cc, {3'(d), 1'b1, 4'h0});
      gap(8'(d > 3 ? 48 : 3 << d));
    end
    wr(a_cc, 8'h20);
    gap(8'd16);
    fin(8'hA5);
    rd(a_res, 8'hA5);
    fin(8'h3C);
    wr(a_res, 8'hFF);
    rd(a_res, 8'h3C);
    wr(a_sc, 8'h00);
    fin(8'h11);
    rd(a_sc, 8'h80);
    rd(a_res, 8'h11);
    rd(a_sc, 8'h00);
    fin(8'h22);
    wr(a_sc, 8'h00);
    rd(a_sc, 8'h00);
    wr(a_sc, 8'h40);
    fin(8'h33);
    chk("converter_irq", 8'(converter_irq), 8'h01);
    rd(a_res, 8'h33);
    chk("converter_irq", 8'(converter_irq), 8'h00);
    fin(8'h44);
    wr(a_sc, 8'h40);
    chk("converter_irq", 8'(converter_irq), 8'h00);
    chk("irq", 8'(irq), 8'h00);
    rd(adc_ctl_pkg::OFS_IRQ_STATUS, 8'h01);
    wr(adc_ctl_pkg::OFS_IRQ_MASK, 8'h01);
    chk("irq", 8'(irq), 8'h01);
    wr(adc_ctl_pkg::OFS_IRQ_STATUS, 8'h01);
    chk("irq", 8'(irq), 8'h00);
    fin(8'h55);
    fin(8'h66);
    rd(adc_ctl_pkg::OFS_IRQ_STATUS, 8'h03);
    rd(4'hF, 8'h00);
    close_out;
  end
endmodule
bind adc_clock_prescaler_result adc_ctl_monitor u_mon (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .bus_tick, .conv_finish, .conv_code, .conv_tick, .converter_irq);
